// [rtl/sru_top.sv]
// Square root unit on the controller's special function register bus
//
// Operation
// - Root of 40-bit radicand, five byte registers
// - 20-bit root readable from three bytes
// - Lowest radicand byte write starts; others store
// - Restoring method, one bit per clock
// - No interrupt; result ready within four machine cycles
// - Radicand bits 39 to 36 ignored
// - Result bits 23 to 20 read zero
// - Each low byte write restarts with current bytes
`timescale 1ns/1ns
`default_nettype none
module sru_top
	import sru_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Special function register bus
	input  wire sru_pkg::sru_sfrReq_s sfrReq,
	output logic             sfrHit,
	output sru_pkg::sru_sfrRsp_s      sfrRsp,
	// Status, not routed to any interrupt controller
	output logic             rootBusy,
	output logic             rootDone,
	output logic             rootSettled
);
	import sru_pkg::*;

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic [1:0]  rstSync_q;
	logic        rstSyncN;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync_q <= 2'b00;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end

	assign rstSyncN = rstSync_q[1];

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	// Index 0..4 radicand bytes, 5..7 result bytes, 8 for a miss
	function automatic logic [3:0] decodeIdx(input logic [7:0] addr);
		logic [3:0] idx;
		idx = 4'h8;
		case (addr)
			SRU_ADDR_RAD0: idx = 4'h0;
			SRU_ADDR_RAD1: idx = 4'h1;
			SRU_ADDR_RAD2: idx = 4'h2;
			SRU_ADDR_RAD3: idx = 4'h3;
			SRU_ADDR_RAD4: idx = 4'h4;
			SRU_ADDR_RES0: idx = 4'h5;
			SRU_ADDR_RES1: idx = 4'h6;
			SRU_ADDR_RES2: idx = 4'h7;
			default:       idx = 4'h8;
		endcase
		return idx;
	endfunction

	logic [3:0]  accIdx;
	logic        wrHit;
	logic        rdHit;
	logic        startCalc;

	assign accIdx    = decodeIdx(sfrReq.addr);
	assign sfrHit    = (accIdx != 4'h8) && (sfrReq.wrEn || sfrReq.rdEn);
	assign wrHit     = sfrReq.wrEn && (accIdx < 4'h5);
	assign rdHit     = sfrReq.rdEn && (accIdx != 4'h8);
	// Only the lowest byte triggers; upper bytes are plain storage
	assign startCalc = sfrReq.wrEn && (accIdx == 4'h0);

	// ---------------------------------------------------------------
	// Radicand byte registers
	// ---------------------------------------------------------------
	logic [7:0]  radByte_q [SRU_RAD_BYTES];
	logic [39:0] radNow;

	genvar gi;
	generate
		for (gi = 0; gi < SRU_RAD_BYTES; gi++)
		begin : g_rad
			always_ff @(posedge ref_clk or negedge rstSyncN)
			begin
				if (!rstSyncN)
					radByte_q[gi] <= SRU_RAD_RESET;
				else if (wrHit && accIdx == 4'(gi))
					radByte_q[gi] <= sfrReq.wrData;
			end
		end
	endgenerate

	// The triggering byte is taken straight from the bus, so the run
	// starts on the write edge and still sees every current byte.
	assign radNow = {radByte_q[4], radByte_q[3], radByte_q[2],
		radByte_q[1], sfrReq.wrData};

	// ---------------------------------------------------------------
	// Engine
	// ---------------------------------------------------------------
	logic [19:0] rootVal;
	logic        coreBusy;
	logic        coreDone;

	sru_core u_sru_core (
		.clk      (ref_clk),
		.rstN     (rstSyncN),
		.start    (startCalc),
		.radicand (radNow),
		.busy     (coreBusy),
		.done     (coreDone),
		.root     (rootVal)
	);

	// ---------------------------------------------------------------
	// Fixed interval tracking
	// ---------------------------------------------------------------
	// Software cannot poll a completion interrupt, so rootSettled
	// reports when the promised interval has run out; the engine
	// finishes well inside it.
	logic [5:0]  sinceStart_q;
	logic        settled_q;

	always_ff @(posedge ref_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			sinceStart_q <= '0;
			settled_q    <= 1'b1;
		end
		else if (startCalc)
		begin
			sinceStart_q <= '0;
			settled_q    <= 1'b0;
		end
		else if (!settled_q)
		begin
			sinceStart_q <= sinceStart_q + 6'h01;
			if (sinceStart_q == SRU_GUARANTEE_CLKS - 6'h01)
				settled_q <= 1'b1;
		end
	end

	assign rootBusy    = coreBusy;
	assign rootDone    = coreDone;
	assign rootSettled = settled_q;

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	logic [7:0]  rdMux;

	always_comb
	begin
		rdMux = 8'h00;
		case (accIdx)
			4'h0: rdMux = radByte_q[0];
			4'h1: rdMux = radByte_q[1];
			4'h2: rdMux = radByte_q[2];
			4'h3: rdMux = radByte_q[3];
			// Ignored top nibble never shows on read-back
			4'h4: rdMux = {4'h0, radByte_q[4][3:0]};
			4'h5: rdMux = rootVal[7:0];
			4'h6: rdMux = rootVal[15:8];
			4'h7: rdMux = {4'h0, rootVal[19:16]};
			default: rdMux = 8'h00;
		endcase
	end

	// Read data comes one cycle after the request, from a flop
	always_ff @(posedge ref_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			sfrRsp.rdData  <= 8'h00;
			sfrRsp.rdValid <= 1'b0;
		end
		else
		begin
			sfrRsp.rdValid <= rdHit;
			sfrRsp.rdData  <= rdHit ? rdMux : 8'h00;
		end
	end

endmodule // sru_top
`default_nettype wire

// [rtl/sru_pkg.sv]
// Shared constants and types for the square root unit
package sru_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] SRU_ADDR_RAD0 = 8'hE8;
	localparam logic [7:0] SRU_ADDR_RAD1 = 8'hE9;
	localparam logic [7:0] SRU_ADDR_RAD2 = 8'hEA;
	localparam logic [7:0] SRU_ADDR_RAD3 = 8'hEB;
	localparam logic [7:0] SRU_ADDR_RAD4 = 8'hEC;
	localparam logic [7:0] SRU_ADDR_RES0 = 8'hED;
	localparam logic [7:0] SRU_ADDR_RES1 = 8'hEE;
	localparam logic [7:0] SRU_ADDR_RES2 = 8'hEF;

	// ---------------------------------------------------------------
	// Field layout and reset values
	// ---------------------------------------------------------------
	localparam int         SRU_RAD_BYTES  = 5;
	localparam int         SRU_RES_BYTES  = 3;
	localparam int         SRU_RAD_W      = 40;
	localparam int         SRU_ROOT_W     = 20;
	localparam int         SRU_REM_W      = 21;
	localparam int         SRU_TOP_KEEP_W = 4;
	localparam logic [7:0] SRU_RAD_RESET  = 8'h00;
	localparam logic [19:0] SRU_ROOT_RESET = 20'h0_0000;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int         SRU_CLK_PERIOD_NS  = 4;
	localparam int         SRU_CNT_W          = 6;
	localparam logic [5:0] SRU_CALC_CYCLES    = 6'h14;
	localparam int         SRU_MC_CLKS        = 12;
	localparam int         SRU_GUARANTEE_MC   = 4;
	localparam logic [5:0] SRU_GUARANTEE_CLKS =
		6'(SRU_MC_CLKS * SRU_GUARANTEE_MC);

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       wrEn;
		logic       rdEn;
		logic [7:0] wrData;
	} sru_sfrReq_s;

	typedef struct packed {
		logic [7:0] rdData;
		logic       rdValid;
	} sru_sfrRsp_s;

	typedef enum logic [0:0] {
		SRU_IDLE = 1'b0,
		SRU_RUN  = 1'b1
	} sru_state_e;

endpackage

// [rtl/sru_core.sv]
// Bit-serial restoring integer square root engine
`timescale 1ns/1ns
`default_nettype none
module sru_core
	import sru_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstN,
	// Request
	input  wire logic        start,
	input  wire logic [39:0] radicand,
	// Result
	output logic             busy,
	output logic             done,
	output logic [19:0]      root
);
	import sru_pkg::*;

	sru_state_e          state_q;
	logic [39:0]         radSh_q;
	logic [20:0]         rem_q;
	logic [19:0]         acc_q;
	logic [5:0]          cnt_q;
	logic [22:0]         remShift;
	logic [22:0]         trial;
	logic [22:0]         diff;
	logic                take;
	logic [20:0]         remNext;
	logic [19:0]         accNext;

	// ---------------------------------------------------------------
	// One root bit per cycle
	// ---------------------------------------------------------------
	always_comb
	begin
		remShift = {rem_q, radSh_q[39:38]};
		trial    = {1'b0, acc_q, 2'b01};
		diff     = remShift - trial;
		take     = (remShift >= trial);
		remNext  = take ? diff[20:0] : remShift[20:0];
		accNext  = {acc_q[18:0], take};
	end

	// ---------------------------------------------------------------
	// Sequencing; a new start always wins over a run in progress
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			state_q <= SRU_IDLE;
			radSh_q <= '0;
			rem_q   <= '0;
			acc_q   <= '0;
			cnt_q   <= '0;
		end
		else if (start)
		begin
			// Top nibble is forced clear so it cannot reach the root
			state_q <= SRU_RUN;
			radSh_q <= {{SRU_TOP_KEEP_W{1'b0}}, radicand[35:0]};
			rem_q   <= '0;
			acc_q   <= '0;
			cnt_q   <= '0;
		end
		else
		begin
			case (state_q)
				SRU_RUN:
				begin
					radSh_q <= {radSh_q[37:0], 2'b00};
					rem_q   <= remNext;
					acc_q   <= accNext;
					cnt_q   <= cnt_q + 6'h01;
					if (cnt_q == SRU_CALC_CYCLES - 6'h01)
						state_q <= SRU_IDLE;
				end
				default:
					state_q <= SRU_IDLE;
			endcase
		end
	end

	// Finished root is held until the next run completes
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			root <= SRU_ROOT_RESET;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!start && state_q == SRU_RUN
				&& cnt_q == SRU_CALC_CYCLES - 6'h01)
			begin
				root <= accNext;
				done <= 1'b1;
			end
		end
	end

	assign busy = (state_q == SRU_RUN);

endmodule // sru_core
`default_nettype wire

// [tb/sru_top_properties.sv]
// Concurrent checks on the square root unit ports
`timescale 1ns/1ns
`default_nettype none
module sru_top_properties
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Register bus
	input  wire sru_pkg::sru_sfrReq_s sfrReq,
	input  wire logic                 sfrHit,
	input  wire sru_pkg::sru_sfrRsp_s sfrRsp,
	// Status
	input  wire logic                 rootBusy,
	input  wire logic                 rootDone,
	input  wire logic                 rootSettled
);
	import sru_pkg::*;
	logic       startW;
	logic       mapRd;
	logic       topRd;
	logic [5:0] elapsed_q;
	assign startW = sfrReq.wrEn && sfrReq.addr == SRU_ADDR_RAD0;
	assign mapRd = sfrReq.rdEn && sfrReq.addr[7:3] == 5'h1D;
	assign topRd = sfrReq.rdEn && (sfrReq.addr == SRU_ADDR_RAD4 || sfrReq.addr == SRU_ADDR_RES2);
	// Edges since the last start, held at 49 so the settle point stays visible
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			elapsed_q <= 6'h00;
		else if (startW)
			elapsed_q <= 6'h01;
		else if (elapsed_q != 6'h00 && elapsed_q < 6'h31)
			elapsed_q <= elapsed_q + 6'h01;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_START_BUSY: assert property (startW |=> rootBusy && !rootSettled)
		else $error("start write did not launch a run");
	AST_DONE_ONLY_AT_20: assert property (rootDone |-> elapsed_q == 6'h15)
		else $error("done pulse at wrong distance from start");
	AST_DONE_GIVEN: assert property (elapsed_q == 6'h15 |-> rootDone)
		else $error("done pulse missing after twenty bits");
	AST_BUSY_SPAN: assert property (rootBusy |-> elapsed_q inside {[1:20]})
		else $error("busy outside the calculation span");
	AST_BUSY_END: assert property ($fell(rootBusy) |-> rootDone)
		else $error("run ended without done");
	AST_SETTLED: assert property (rootSettled == (elapsed_q == 6'h00 || elapsed_q == 6'h31))
		else $error("settled flag off the fixed interval");
	AST_READ_ANSWER: assert property (mapRd |=> sfrRsp.rdValid)
		else $error("mapped read not answered");
	AST_NO_ANSWER: assert property (!mapRd |=> !sfrRsp.rdValid && sfrRsp.rdData == 8'h00)
		else $error("answer without a mapped read");
	AST_HIT: assert property (sfrHit ==
		(sfrReq.addr[7:3] == 5'h1D && (sfrReq.wrEn || sfrReq.rdEn)))
		else $error("hit decode wrong");
	AST_TOP_ZERO: assert property (topRd |=> sfrRsp.rdData[7:4] == 4'h0)
		else $error("unused top bits read nonzero");
	cover property (startW ##[1:19] startW);
	cover property (rootDone);
	cover property (topRd);
endmodule // sru_top_properties
bind sru_top sru_top_properties u_sru_top_properties (.ref_clk(ref_clk), .rst_n(rst_n),
	.sfrReq(sfrReq), .sfrHit(sfrHit), .sfrRsp(sfrRsp), .rootBusy(rootBusy),
	.rootDone(rootDone), .rootSettled(rootSettled));
`default_nettype wire

// [tb/sru_cpu_model.sv]
// Controller side model driving the special function register bus
`timescale 1ns/1ns
`default_nettype none
module sru_cpu_model
(
	// Clock
	input  wire logic                 clk,
	// Register bus
	output sru_pkg::sru_sfrReq_s      req,
	input  wire sru_pkg::sru_sfrRsp_s rsp
);
	import sru_pkg::*;
	initial req = '0;
	// Released lines carry inverted values so stale address or data cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{a, 1'b1, 1'b0, d};
		@(posedge clk) req <= '{~a, 1'b0, 1'b0, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output sru_sfrRsp_s r);
		@(posedge clk) req <= '{a, 1'b0, 1'b1, 8'h5A};
		@(posedge clk) req <= '{~a, 1'b0, 1'b0, 8'hA5};
		@(posedge clk) r = rsp;
	endtask
	// Low byte goes last so the run sees all five bytes
	task automatic calc(input logic [39:0] v);
		for (int i = 4; i >= 0; i--)
			wr(SRU_ADDR_RAD0 + 8'(i), v[i*8 +: 8]);
		repeat (SRU_GUARANTEE_CLKS) @(posedge clk);
	endtask
endmodule // sru_cpu_model
`default_nettype wire

// [tb/tb_square_root_unit.sv]
// Self-checking bench for the square root unit
`timescale 1ns/1ns
`default_nettype none
module tb_square_root_unit;
	import sru_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	sru_sfrReq_s sfrReq;
	sru_sfrRsp_s sfrRsp;
	sru_sfrRsp_s r;
	logic        sfrHit;
	logic        rootBusy;
	logic        rootDone;
	logic        rootSettled;
	int          err_count = 0;
	int          cmp_count = 0;
	int          seed = 32'h84d2;
	logic [39:0] rad;
	logic [23:0] got;
	logic [39:0] cor [4] = '{40'h00_0000_0000, 40'hFF_FFFF_FFFF, 40'hF0_0000_0000, 40'h00_0000_0010};
`define CHK(a, b) \
	begin \
		cmp_count++; \
		if ((a) !== (b)) \
		begin \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
			err_count++; \
		end \
	end
	always #2 ref_clk = ~ref_clk;
	sru_top u_sru_top (.ref_clk(ref_clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrHit(sfrHit),
		.sfrRsp(sfrRsp), .rootBusy(rootBusy), .rootDone(rootDone), .rootSettled(rootSettled));
	sru_cpu_model u_sru_cpu_model (.clk(ref_clk), .req(sfrReq), .rsp(sfrRsp));
	function automatic logic [19:0] isqrt(input logic [39:0] v);
		logic [19:0] q;
		logic [19:0] t;
		q = '0;
		for (int i = 19; i >= 0; i--)
		begin
			t = q | (20'h1 << i);
			if (40'(t) * 40'(t) <= {4'h0, v[35:0]})
				q = t;
		end
		return q;
	endfunction
	task automatic getRoot(output logic [23:0] g);
		for (int i = 0; i < 3; i++)
		begin
			u_sru_cpu_model.rd(SRU_ADDR_RES0 + 8'(i), r);
			`CHK(r.rdValid, 1'b1)
			g[i*8 +: 8] = r.rdData;
		end
	endtask
	task automatic run(input logic [39:0] v);
		u_sru_cpu_model.calc(v);
		getRoot(got);
		`CHK(got, {4'h0, isqrt(v)})
		u_sru_cpu_model.rd(SRU_ADDR_RAD4, r);
		`CHK(r.rdData, {4'h0, v[35:32]})
	endtask
	task automatic conclude();
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#80000;
		err_count++;
		conclude();
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int a = 8'hE7; a <= 8'hEF; a++)
		begin
			u_sru_cpu_model.rd(8'(a), r);
			`CHK({r.rdValid, r.rdData}, {a != 8'hE7, 8'h00})
		end
		foreach (cor[i])
			run(cor[i]);
		repeat (12)
			run(40'({$random(seed), $random(seed)}));
		// Restart mid-run: only the last low byte may count
		rad = 40'({$random(seed), $random(seed)});
		u_sru_cpu_model.calc(rad);
		u_sru_cpu_model.wr(SRU_ADDR_RAD0, ~rad[7:0]);
		repeat (5) @(posedge ref_clk);
		rad[7:0] = rad[7:0] ^ 8'h5A;
		u_sru_cpu_model.wr(SRU_ADDR_RAD0, rad[7:0]);
		repeat (SRU_GUARANTEE_CLKS) @(posedge ref_clk);
		getRoot(got);
		`CHK(got, {4'h0, isqrt(rad)})
		u_sru_cpu_model.wr(SRU_ADDR_RES2, 8'hFF);
		u_sru_cpu_model.rd(SRU_ADDR_RES2, r);
		`CHK(r.rdData, 8'({4'h0, isqrt(rad)} >> 16))
		conclude();
	end
endmodule // tb_square_root_unit
`default_nettype wire
